// *** rtl/cfq_regs.vh ***
/*
 * Register map, field positions, reset values and timing counts of the
 * frame write queue. Assumes a 32-bit Avalon-MM slave on byte addresses.
 */
`ifndef CFQ_REGS_VH
`define CFQ_REGS_VH

// Byte offsets, one aligned word each
`define CFQ_CTRL_ADDR 6'h00
`define CFQ_ID_ADDR 6'h04
`define CFQ_TYPE_ADDR 6'h08
`define CFQ_LEN_ADDR 6'h0c
`define CFQ_DLO_ADDR 6'h10
`define CFQ_DHI_ADDR 6'h14
`define CFQ_DELAY_ADDR 6'h18
`define CFQ_CMD_ADDR 6'h1c
`define CFQ_STATE_ADDR 6'h20
`define CFQ_ISTAT_ADDR 6'h24
`define CFQ_IMASK_ADDR 6'h28
`define CFQ_RESULT_ADDR 6'h2c
`define CFQ_WCODE_ADDR 6'h30

// Field positions
`define CFQ_CTRL_ZERO_LEN 0
`define CFQ_CMD_SINGLE 0
`define CFQ_CMD_MULTI 1
`define CFQ_ID_EXT_BIT 29
`define CFQ_ST_ALL_SENT 0
`define CFQ_ST_FULL 1
`define CFQ_ST_BUSY 2
`define CFQ_EV_ALL_SENT 0
`define CFQ_EV_OVERFLOW 1
`define CFQ_EV_WARN 2

// Frame type codes
`define CFQ_TYPE_DATA 1'b0
`define CFQ_TYPE_REMOTE 1'b1

// Payload limits
`define CFQ_MAX_BYTES 4'h8

// Result and warning codes
`define CFQ_CODE_OK 32'h00000000
`define CFQ_CODE_OVERFLOW 32'hbff62008
`define CFQ_CODE_COMM_WARN 32'h3ff6200b

// Reset values
`define CFQ_RST_WORD 32'h00000000
`define CFQ_RST_EVENTS 3'h0

// Timed spacing unit and clock
`define CFQ_TICK_NS 1000
`define CFQ_CLK_NS 4
`define CFQ_TICK_CYCLES (`CFQ_TICK_NS / `CFQ_CLK_NS)

`endif

// *** rtl/cfq_fifo.v ***
/*
 * Frame queue storage: a circular array with honest full and empty.
 * Assumes push is only issued when the queue may take it; in overwrite
 * mode the capacity is one entry and a new push replaces it.
 */
`timescale 1ns/10ps
module cfq_fifo #(
	parameter W = 116,
	parameter DL = 4
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire overwrite_in,
	input wire push_in,
	input wire [W-1:0] push_data_in,
	input wire pop_in,
	output wire [W-1:0] head_out,
	output wire empty_out,
	output wire full_out,
	output wire [DL:0] count_out
);
	localparam [DL:0] DEPTH = {1'b1, {DL{1'b0}}};
	localparam [DL:0] ONE = {{DL{1'b0}}, 1'b1};

	reg [W-1:0] mem [0:(1<<DL)-1];
	reg [DL-1:0] rd_ptr;
	reg [DL-1:0] wr_ptr;
	reg [DL:0] count;
	wire do_over;
	wire do_push;
	wire do_pop;

	assign empty_out = (count == {(DL+1){1'b0}});
	// Zero-length mode holds a single slot
	assign full_out = overwrite_in ? ~empty_out : (count == DEPTH);
	assign count_out = count;
	assign head_out = mem[rd_ptr];
	assign do_pop = pop_in & ~empty_out;
	assign do_over = push_in & overwrite_in & ~empty_out & ~do_pop;
	assign do_push = push_in & ~do_over & (~full_out | do_pop);

	// Storage array has no reset; only valid entries are ever read
	always @(posedge clk_in) begin
		if (do_over)
			mem[rd_ptr] <= push_data_in;
		else if (do_push)
			mem[wr_ptr] <= push_data_in;
	end

	// Pointers and occupancy
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_ptr <= {DL{1'b0}};
			wr_ptr <= {DL{1'b0}};
			count <= {(DL+1){1'b0}};
		end else begin
			if (do_pop)
				rd_ptr <= rd_ptr + ONE[DL-1:0];
			if (do_push)
				wr_ptr <= wr_ptr + ONE[DL-1:0];
			if (do_push && !do_pop)
				count <= count + ONE;
			else if (do_pop && !do_push)
				count <= count - ONE;
		end
	end
endmodule // cfq_fifo

// *** rtl/cfq_sched.v ***
/*
 * Release timer for timed frames. Measures ticks since the launch of the
 * previous timed frame. Assumes launch pulses come from the transmit logic.
 */
`timescale 1ns/10ps
`include "cfq_regs.vh"
module cfq_sched #(
	parameter TICK_CYCLES = `CFQ_TICK_CYCLES
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire head_timed_in,
	input wire [15:0] head_delay_in,
	input wire launch_timed_in,
	output wire release_out
);
	reg [15:0] prescale;
	reg [15:0] since_ref;
	reg have_ref;
	wire tick;

	assign tick = (prescale == TICK_CYCLES[15:0] - 16'h0001);
	// Untimed frames go at once; timed ones wait out their spacing
	assign release_out = ~head_timed_in | ~have_ref | (since_ref >= head_delay_in);

	// Only timed launches move the reference, so untimed frames between
	// them leave the spacing alone
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			prescale <= 16'h0000;
			since_ref <= 16'h0000;
			have_ref <= 1'b0;
		end else begin
			prescale <= tick ? 16'h0000 : prescale + 16'h0001;
			if (launch_timed_in) begin
				since_ref <= 16'h0000;
				have_ref <= 1'b1;
			end else if (tick && since_ref != 16'hffff) begin
				since_ref <= since_ref + 16'h0001;
			end
		end
	end
endmodule // cfq_sched

// *** rtl/cfq_top.v ***
/*
 * Transmit write queue of a CAN network interface with an Avalon-MM
 * register slave, an interrupt, and a frame port to a CAN controller.
 * Assumes the controller runs on CLOCK_IN and pulses done or error per
 * attempt while a request is held.
 *
// Summary of operation
// - Single-frame write enqueues and completes at once; sending happens later.
// - All-transmitted state sets once every queued frame has gone out successfully.
// - Every single-frame write clears the all-transmitted state.
// - Single and timed writes share one queue; untimed follow timed ones directly.
// - Untimed frames do not shift the spacing of later timed frames.
// - Write into a full queue is refused with the overflow code.
// - Bus trouble raises a communication warning with its code, not an error.
// - Accepted frames are retried until sent unless serious bus failure persists.
// - Zero queue length allowed: each new frame replaces the pending one.
// - Frame type code 0 sends a data frame, code 1 a remote frame.
// - Identifier is 11-bit standard unless bit 29 selects 29-bit extended.
// - Data frames carry up to 8 bytes per the byte count, default zero.
// - Remote frames send the byte count as length code and no payload.
// - A frame counts as sent only after winning arbitration and being acknowledged.
// - All-transmitted state starts true before any frame is written.
 */
`timescale 1ns/10ps
`include "cfq_regs.vh"
module cfq_top #(
	parameter DEPTH_LOG2 = 4,
	parameter TICK_CYCLES = `CFQ_TICK_CYCLES
) (
	input wire CLOCK_IN,
	input wire RST_N_IN,
	input wire [5:0] AVS_ADDRESS_IN,
	input wire AVS_READ_IN,
	input wire AVS_WRITE_IN,
	input wire [31:0] AVS_WRITEDATA_IN,
	input wire [3:0] AVS_BYTEENABLE_IN,
	output reg [31:0] AVS_READDATA_OUT,
	output wire AVS_WAITREQUEST_OUT,
	output wire IRQ_OUT,
	output wire ALL_SENT_OUT,
	output reg TX_REQ_OUT,
	output reg [28:0] TX_ID_OUT,
	output reg TX_EXT_OUT,
	output reg TX_RTR_OUT,
	output reg [3:0] TX_DLC_OUT,
	output reg [63:0] TX_DATA_OUT,
	input wire TX_DONE_IN,
	input wire TX_ERR_IN,
	input wire BUS_FAULT_IN
);
	localparam EW = 116;
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	// Byte-lane merge for register writes
	function [31:0] be_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] be;
		integer i;
		begin
			be_merge = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					be_merge[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	// Bus slave state
	reg ack;
	wire rd_done;
	wire wr_done;

	// Staging and control registers
	reg zero_len;
	reg [31:0] id_word;
	reg type_code;
	reg [7:0] len_word;
	reg [31:0] data_lo;
	reg [31:0] data_hi;
	reg [15:0] delay;
	reg [2:0] irq_status;
	reg [2:0] irq_mask;
	reg [31:0] result_code;
	reg warn_seen;
	reg all_sent;
	reg state;

	// Queue side
	wire cmd_single;
	wire cmd_multi;
	wire cmd_any;
	wire q_full;
	wire q_empty;
	wire [DEPTH_LOG2:0] q_count;
	wire [EW-1:0] q_head;
	wire push;
	wire pop;
	wire release_ok;
	wire launch_timed;
	wire refused;
	wire tx_success;
	wire tx_abort;
	wire [2:0] events;
	wire ext_sel;
	wire [28:0] id_sel;
	wire [3:0] dlc_sel;
	wire [63:0] data_sel;
	wire [EW-1:0] entry;
	wire [31:0] delay_merged;

	// Every access takes one wait cycle, then completes
	assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack;
	assign rd_done = AVS_READ_IN & ack;
	assign wr_done = AVS_WRITE_IN & ack;

	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			ack <= 1'b0;
		else
			ack <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack;
	end

	// Command decode; a command write returns at once, sending is later
	assign cmd_single = wr_done && AVS_ADDRESS_IN == `CFQ_CMD_ADDR &&
		AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[`CFQ_CMD_SINGLE];
	assign cmd_multi = wr_done && AVS_ADDRESS_IN == `CFQ_CMD_ADDR &&
		AVS_BYTEENABLE_IN[0] && !AVS_WRITEDATA_IN[`CFQ_CMD_SINGLE] &&
		AVS_WRITEDATA_IN[`CFQ_CMD_MULTI];
	assign cmd_any = cmd_single | cmd_multi;

	// Full queue refuses the frame, except in zero-length mode or when the head launches in the same cycle
	assign refused = cmd_any & q_full & ~zero_len & ~pop;
	assign push = cmd_any & ~refused;

	// Frame fields as put on the wire
	assign ext_sel = id_word[`CFQ_ID_EXT_BIT];
	assign id_sel = ext_sel ? id_word[28:0] : {18'h0, id_word[10:0]};
	// Byte count capped at eight; reset value zero stands for unset
	assign dlc_sel = (len_word > {4'h0, `CFQ_MAX_BYTES}) ? `CFQ_MAX_BYTES : len_word[3:0];
	// Remote frames keep the length code but never carry payload
	assign data_sel = (type_code == `CFQ_TYPE_REMOTE) ? 64'h0 : {data_hi, data_lo};
	assign entry = {cmd_multi, cmd_multi ? delay : 16'h0000, type_code, ext_sel,
		id_sel, dlc_sel, data_sel};
	// Delay register keeps only its low half-word lanes
	assign delay_merged = be_merge({16'h0000, delay}, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

	// One shared queue in write order for both paths
	cfq_fifo #(
		.W(EW),
		.DL(DEPTH_LOG2)
	) u_fifo (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.overwrite_in(zero_len),
		.push_in(push),
		.push_data_in(entry),
		.pop_in(pop),
		.head_out(q_head),
		.empty_out(q_empty),
		.full_out(q_full),
		.count_out(q_count)
	);

	cfq_sched #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_sched (
		.clk_in(CLOCK_IN),
		.rst_n_in(RST_N_IN),
		.head_timed_in(q_head[EW-1] & ~q_empty),
		.head_delay_in(q_head[EW-2 -: 16]),
		.launch_timed_in(launch_timed),
		.release_out(release_ok)
	);

	// Launch the head once idle and its spacing has elapsed
	assign pop = (state == ST_IDLE) & ~q_empty & release_ok;
	assign launch_timed = pop & q_head[EW-1];
	// Done means arbitration won and acknowledged
	assign tx_success = (state == ST_SEND) & TX_DONE_IN;
	// Persistent serious failure ends retrying and drops the frame
	assign tx_abort = (state == ST_SEND) & BUS_FAULT_IN & ~TX_DONE_IN;

	// Transmit sequencer; errors keep the request up for a retry
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			state <= ST_IDLE;
			TX_REQ_OUT <= 1'b0;
			TX_ID_OUT <= 29'h0;
			TX_EXT_OUT <= 1'b0;
			TX_RTR_OUT <= 1'b0;
			TX_DLC_OUT <= 4'h0;
			TX_DATA_OUT <= 64'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (pop) begin
						state <= ST_SEND;
						TX_REQ_OUT <= 1'b1;
						TX_RTR_OUT <= q_head[98];
						TX_EXT_OUT <= q_head[97];
						TX_ID_OUT <= q_head[96:68];
						TX_DLC_OUT <= q_head[67:64];
						TX_DATA_OUT <= q_head[63:0];
					end
				end
				ST_SEND: begin
					if (tx_success || tx_abort) begin
						state <= ST_IDLE;
						TX_REQ_OUT <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
					TX_REQ_OUT <= 1'b0;
				end
			endcase
		end
	end

	// All-transmitted starts true and clears on any write command
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			all_sent <= 1'b1;
		else if (cmd_any)
			all_sent <= 1'b0;
		else if (tx_success && q_empty)
			all_sent <= 1'b1;
	end
	assign ALL_SENT_OUT = all_sent;

	// Events: all sent, overflow, bus warning on error or serious failure
	assign events[`CFQ_EV_ALL_SENT] = tx_success & q_empty & ~cmd_any;
	assign events[`CFQ_EV_OVERFLOW] = refused;
	assign events[`CFQ_EV_WARN] = (state == ST_SEND) & (TX_ERR_IN | BUS_FAULT_IN);

	// Sticky status; a read clears it, but a new event in that cycle wins
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			irq_status <= `CFQ_RST_EVENTS;
		else if (rd_done && AVS_ADDRESS_IN == `CFQ_ISTAT_ADDR)
			irq_status <= events;
		else
			irq_status <= irq_status | events;
	end
	assign IRQ_OUT = |(irq_status & irq_mask);

	// Warning stays until software reads its code
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			warn_seen <= 1'b0;
		else if (events[`CFQ_EV_WARN])
			warn_seen <= 1'b1;
		else if (rd_done && AVS_ADDRESS_IN == `CFQ_WCODE_ADDR)
			warn_seen <= 1'b0;
	end

	// Result of the last write command: success or overflow
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			result_code <= `CFQ_CODE_OK;
		else if (refused)
			result_code <= `CFQ_CODE_OVERFLOW;
		else if (push)
			result_code <= `CFQ_CODE_OK;
	end

	// Software-writable registers with byte lanes
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			zero_len <= 1'b0;
			id_word <= `CFQ_RST_WORD;
			type_code <= `CFQ_TYPE_DATA;
			len_word <= 8'h00;
			data_lo <= `CFQ_RST_WORD;
			data_hi <= `CFQ_RST_WORD;
			delay <= 16'h0000;
			irq_mask <= `CFQ_RST_EVENTS;
		end else if (wr_done) begin
			case (AVS_ADDRESS_IN)
				`CFQ_CTRL_ADDR: if (AVS_BYTEENABLE_IN[0])
					zero_len <= AVS_WRITEDATA_IN[`CFQ_CTRL_ZERO_LEN];
				`CFQ_ID_ADDR: id_word <= be_merge(id_word, AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN);
				`CFQ_TYPE_ADDR: if (AVS_BYTEENABLE_IN[0])
					type_code <= AVS_WRITEDATA_IN[0];
				`CFQ_LEN_ADDR: if (AVS_BYTEENABLE_IN[0])
					len_word <= AVS_WRITEDATA_IN[7:0];
				`CFQ_DLO_ADDR: data_lo <= be_merge(data_lo, AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN);
				`CFQ_DHI_ADDR: data_hi <= be_merge(data_hi, AVS_WRITEDATA_IN,
					AVS_BYTEENABLE_IN);
				`CFQ_DELAY_ADDR: delay <= delay_merged[15:0];
				`CFQ_IMASK_ADDR: if (AVS_BYTEENABLE_IN[0])
					irq_mask <= AVS_WRITEDATA_IN[2:0];
				default: begin
				end
			endcase
		end
	end

	// Read data is registered in the wait cycle, valid when waitrequest drops
	always @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			AVS_READDATA_OUT <= `CFQ_RST_WORD;
		end else if (AVS_READ_IN && !ack) begin
			case (AVS_ADDRESS_IN)
				`CFQ_CTRL_ADDR: AVS_READDATA_OUT <= {31'h0, zero_len};
				`CFQ_ID_ADDR: AVS_READDATA_OUT <= id_word;
				`CFQ_TYPE_ADDR: AVS_READDATA_OUT <= {31'h0, type_code};
				`CFQ_LEN_ADDR: AVS_READDATA_OUT <= {24'h0, len_word};
				`CFQ_DLO_ADDR: AVS_READDATA_OUT <= data_lo;
				`CFQ_DHI_ADDR: AVS_READDATA_OUT <= data_hi;
				`CFQ_DELAY_ADDR: AVS_READDATA_OUT <= {16'h0, delay};
				`CFQ_STATE_ADDR: AVS_READDATA_OUT <= {16'h0,
					{(7-DEPTH_LOG2){1'b0}}, q_count, 5'h00,
					state, q_full, all_sent};
				`CFQ_ISTAT_ADDR: AVS_READDATA_OUT <= {29'h0, irq_status};
				`CFQ_IMASK_ADDR: AVS_READDATA_OUT <= {29'h0, irq_mask};
				`CFQ_RESULT_ADDR: AVS_READDATA_OUT <= result_code;
				`CFQ_WCODE_ADDR: AVS_READDATA_OUT <= warn_seen ?
					`CFQ_CODE_COMM_WARN : `CFQ_CODE_OK;
				default: AVS_READDATA_OUT <= `CFQ_RST_WORD;
			endcase
		end
	end
endmodule // cfq_top

// *** sim/cfq_checker.sv ***
/*
 * Concurrent checks on the frame write queue top ports.
 * Assumes one clock domain and a bench that holds bus requests.
 */
`timescale 1ns/10ps
module cfq_checker (
	input wire CLOCK_IN,
	input wire RST_N_IN,
	input wire [5:0] AVS_ADDRESS_IN,
	input wire AVS_WRITE_IN,
	input wire [31:0] AVS_WRITEDATA_IN,
	input wire AVS_WAITREQUEST_OUT,
	input wire ALL_SENT_OUT,
	input wire TX_REQ_OUT,
	input wire [28:0] TX_ID_OUT,
	input wire TX_EXT_OUT,
	input wire TX_RTR_OUT,
	input wire [3:0] TX_DLC_OUT,
	input wire [63:0] TX_DATA_OUT,
	input wire TX_DONE_IN,
	input wire TX_ERR_IN,
	input wire BUS_FAULT_IN
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);
	// A held access is answered after exactly one wait cycle
	AST_WAIT: assert property (AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
		else $error("bus access not answered in time");
	AST_START: assert property ($rose(RST_N_IN) |-> ALL_SENT_OUT)
		else $error("all sent not set after reset");
	AST_CLR: assert property (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 6'h1c
		&& AVS_WRITEDATA_IN[0] |=> !ALL_SENT_OUT) else $error("all sent kept after write");
	// Completion only follows an acknowledged attempt
	AST_SENT: assert property ($rose(ALL_SENT_OUT) |-> $past(TX_DONE_IN))
		else $error("all sent without success");
	AST_DONE: assert property (TX_REQ_OUT && TX_DONE_IN |=> !TX_REQ_OUT)
		else $error("request held after success");
	AST_RETRY: assert property (TX_REQ_OUT && TX_ERR_IN && !BUS_FAULT_IN |=> TX_REQ_OUT)
		else $error("frame dropped after error");
	AST_HOLD: assert property (TX_REQ_OUT && $past(TX_REQ_OUT) |-> $stable(TX_ID_OUT)
		&& $stable(TX_DATA_OUT) && $stable(TX_DLC_OUT) && $stable(TX_RTR_OUT))
		else $error("frame fields moved");
	AST_RTR: assert property (TX_REQ_OUT && TX_RTR_OUT |-> TX_DATA_OUT == 64'h0)
		else $error("remote frame carries data");
	AST_STD: assert property (TX_REQ_OUT && !TX_EXT_OUT |-> TX_ID_OUT[28:11] == 18'h0)
		else $error("standard id too wide");
	AST_DLC: assert property (TX_REQ_OUT && !TX_RTR_OUT |-> TX_DLC_OUT <= 4'h8)
		else $error("data length above eight");
	cover property (TX_REQ_OUT && TX_ERR_IN);
	cover property (TX_REQ_OUT && TX_RTR_OUT);
	cover property ($rose(ALL_SENT_OUT));
endmodule // cfq_checker
bind cfq_top cfq_checker cfq_checker_i (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
	.AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.ALL_SENT_OUT(ALL_SENT_OUT), .TX_REQ_OUT(TX_REQ_OUT), .TX_ID_OUT(TX_ID_OUT),
	.TX_EXT_OUT(TX_EXT_OUT), .TX_RTR_OUT(TX_RTR_OUT), .TX_DLC_OUT(TX_DLC_OUT),
	.TX_DATA_OUT(TX_DATA_OUT), .TX_DONE_IN(TX_DONE_IN), .TX_ERR_IN(TX_ERR_IN),
	.BUS_FAULT_IN(BUS_FAULT_IN));

// *** sim/cfq_can_model.sv ***
/*
 * CAN controller stand-in: takes one offered frame, fails a set number
 * of attempts, then reports success. Assumes it shares CLOCK_IN.
 */
`timescale 1ns/10ps
module cfq_can_model (
	input wire clk_in,
	input wire rst_n_in,
	input wire req_in,
	input wire [1:0] errs_in,
	input wire fault_in,
	output reg done_out,
	output reg err_out,
	output wire fault_out
);
	reg [2:0] wait_cnt;
	reg [1:0] err_cnt;
	// Serious failure only shows while a frame is offered
	assign fault_out = fault_in & req_in;
	// Each attempt lasts four cycles; success means arbitration won and acked
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		err_out <= 1'b0;
		if (!rst_n_in || !req_in || done_out) begin
			wait_cnt <= 3'h0;
			err_cnt <= errs_in;
		end else if (wait_cnt != 3'h3) begin
			wait_cnt <= wait_cnt + 3'h1;
		end else begin
			wait_cnt <= 3'h0;
			if (err_cnt != 2'h0) begin
				err_out <= 1'b1; // Failed attempt, device must retry
				err_cnt <= err_cnt - 2'h1;
			end else begin
				done_out <= 1'b1;
			end
		end
	end
endmodule // cfq_can_model

// *** sim/tb_can_frame_write_queue.sv ***
/*
 * Self-checking bench for the frame write queue: Avalon-MM master tasks,
 * controller model, and one task per scenario. Assumes TICK_CYCLES of 4.
 */
`timescale 1ns/10ps
module tb_can_frame_write_queue;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [5:0] addr = 6'h00;
	reg rd_en = 1'b0;
	reg wr_en = 1'b0;
	reg [31:0] wdata = 32'h0;
	reg [1:0] errs = 2'h0;
	reg fault = 1'b0;
	wire [31:0] rdata;
	wire waitreq, irq, all_sent, req, ext, rtr, done, err, bus_fault;
	wire [28:0] tx_id;
	wire [3:0] dlc;
	wire [63:0] data;
	reg [31:0] q;
	reg req_d = 1'b0;
	integer err_total = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer lq_id[$];
	integer lq_cyc[$];
	cfq_top #(.DEPTH_LOG2(4), .TICK_CYCLES(4)) cfq_top_i (.CLOCK_IN(clk), .RST_N_IN(rst_n),
		.AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .IRQ_OUT(irq), .ALL_SENT_OUT(all_sent),
		.TX_REQ_OUT(req), .TX_ID_OUT(tx_id), .TX_EXT_OUT(ext), .TX_RTR_OUT(rtr),
		.TX_DLC_OUT(dlc), .TX_DATA_OUT(data), .TX_DONE_IN(done), .TX_ERR_IN(err),
		.BUS_FAULT_IN(bus_fault));
	cfq_can_model cfq_can_model_i (.clk_in(clk), .rst_n_in(rst_n), .req_in(req),
		.errs_in(errs), .fault_in(fault), .done_out(done), .err_out(err),
		.fault_out(bus_fault));
	always #2 clk = ~clk;
	// Launch log and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		req_d <= req;
		if (req === 1'b1 && req_d === 1'b0) begin
			lq_id.push_back(tx_id);
			lq_cyc.push_back(cyc);
		end
		if (cyc == 30000) begin
			err_total = err_total + 1;
			summarize;
		end
	end
	task summarize;
		begin
			if (err_total == 0 && n_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One held access, released only at the edge that sees waitrequest low
	task av(input w, input [5:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr_en <= w;
			rd_en <= !w;
			@(posedge clk);
			while (waitreq !== 1'b0)
				@(posedge clk);
			q = rdata;
			wr_en <= 1'b0;
			rd_en <= 1'b0;
		end
	endtask
	task wait_sent;
		integer n;
		begin
			// Skip the edge of the command write, whose clear is not yet visible
			@(posedge clk);
			for (n = 0; n < 3000 && all_sent !== 1'b1; n = n + 1)
				@(posedge clk);
			chk(all_sent, 1'b1);
		end
	endtask
	task frame(input [31:0] id, input ty, input [7:0] ln, input [28:0] eid, input ee,
		input [3:0] ed, input [63:0] edat);
		integer n;
		begin
			av(1, 6'h04, id);
			av(1, 6'h08, {31'h0, ty});
			if (ln != 8'hff)
				av(1, 6'h0c, {24'h0, ln});
			av(1, 6'h1c, 32'h1);
			@(posedge clk);
			chk(all_sent, 1'b0);
			for (n = 0; n < 100 && req !== 1'b1; n = n + 1)
				@(posedge clk);
			chk(req, 1'b1);
			chk({ext, rtr, dlc, tx_id}, {ee, ty, ed, eid});
			chk(data, edat);
			wait_sent;
			chk(all_sent, 1'b1);
		end
	endtask
	task t_reset;
		begin
			chk(all_sent, 1'b1);
			av(0, 6'h20, 0);
			chk(q[0], 1'b1);
			av(0, 6'h3c, 0);
			chk(q, 32'h0);
			av(0, 6'h1c, 0);
			chk(q, 32'h0);
		end
	endtask
	task t_frames;
		begin
			av(1, 6'h28, 32'h1);
			av(1, 6'h10, 32'h11223344);
			av(1, 6'h14, 32'h55667788);
			frame(32'h7ff, 0, 8'hff, 29'h7ff, 0, 4'h0, 64'h5566778811223344);
			chk(irq, 1'b1);
			av(0, 6'h24, 0);
			chk(q, 32'h1);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
			frame(32'h20000123, 0, 8'h8, 29'h123, 1, 4'h8, 64'h5566778811223344);
			frame(32'h456, 1, 8'h5, 29'h456, 0, 4'h5, 64'h0);
		end
	endtask
	task t_order;
		integer i;
		begin
			av(1, 6'h28, 32'h0);
			errs <= 2'h1;
			lq_id.delete();
			for (i = 1; i < 4; i = i + 1) begin
				av(1, 6'h04, i);
				av(1, 6'h1c, 32'h1);
			end
			wait_sent;
			chk(lq_id.size(), 3);
			for (i = 0; i < lq_id.size(); i = i + 1)
				chk(lq_id[i], i + 1);
			av(0, 6'h30, 0);
			chk(q, 32'h3ff6200b);
			av(0, 6'h24, 0);
			chk(q[2:0], 3'h5);
			chk(irq, 1'b0);
		end
	endtask
	task t_full;
		integer i, n0;
		begin
			errs <= 2'h3;
			// One in flight plus sixteen queued; the last writes must be refused
			for (i = 0; i < 24; i = i + 1)
				av(1, 6'h1c, 32'h1);
			av(0, 6'h2c, 0);
			chk(q, 32'hbff62008);
			av(0, 6'h24, 0);
			chk(q[1], 1'b1);
			wait_sent;
			n0 = lq_id.size();
			av(1, 6'h1c, 32'h1);
			wait_sent;
			chk(lq_id.size(), n0 + 1);
		end
	endtask
	task t_timed;
		integer b;
		begin
			lq_id.delete();
			lq_cyc.delete();
			av(1, 6'h18, 0);
			av(1, 6'h04, 1);
			av(1, 6'h1c, 32'h2);
			av(1, 6'h18, 40);
			av(1, 6'h04, 2);
			av(1, 6'h1c, 32'h2);
			av(1, 6'h04, 3);
			av(1, 6'h1c, 32'h1);
			av(1, 6'h04, 4);
			av(1, 6'h1c, 32'h2);
			wait_sent;
			chk(lq_id.size(), 4);
			if (lq_id.size() == 4) begin
				for (b = 0; b < 4; b = b + 1)
					chk(lq_id[b], b + 1);
				b = lq_cyc[1];
				chk(lq_cyc[2] - b <= 26, 1);
				chk(lq_cyc[3] - b >= 156 && lq_cyc[3] - b <= 170, 1);
			end
		end
	endtask
	task t_fault_zero;
		integer n;
		begin
			fault <= 1'b1;
			av(1, 6'h1c, 32'h1);
			for (n = 0; n < 100 && req !== 1'b1; n = n + 1)
				@(posedge clk);
			chk(req, 1'b1);
			for (n = 0; n < 100 && req !== 1'b0; n = n + 1)
				@(posedge clk);
			chk({req, all_sent}, 2'b00);
			fault <= 1'b0;
			lq_id.delete();
			av(1, 6'h00, 32'h1);
			av(1, 6'h04, 32'h11);
			av(1, 6'h1c, 32'h1);
			av(1, 6'h04, 32'h12);
			av(1, 6'h1c, 32'h1);
			av(1, 6'h04, 32'h13);
			av(1, 6'h1c, 32'h1);
			wait_sent;
			chk(lq_id.size(), 2);
			chk(lq_id[1], 32'h13);
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_frames;
		t_order;
		t_full;
		t_timed;
		t_fault_zero;
		summarize;
	end
endmodule // tb_can_frame_write_queue
